// ---- cmas_defines.vh ----
// Constants for the core memory addressing and status block.
`ifndef CMAS_DEFINES_VH
`define CMAS_DEFINES_VH

// Widths and depths.
`define CMAS_PC_W 15
`define CMAS_STACK_DEPTH 16
`define CMAS_SP_W 5
`define CMAS_PM_AW 12
`define CMAS_PM_DW 14
`define CMAS_BANKS 32
`define CMAS_GPR_PER_BANK 80
`define CMAS_GPR_SIZE 2560
`define CMAS_COMMON_SIZE 16

// Vectors.
`define CMAS_RESET_VECTOR 15'h0000
`define CMAS_INT_VECTOR 15'h0004

// Core register offsets inside every bank.
`define CMAS_OFF_IND0 7'h00
`define CMAS_OFF_IND1 7'h01
`define CMAS_OFF_PCL 7'h02
`define CMAS_OFF_STATUS 7'h03
`define CMAS_OFF_PTR0_LO 7'h04
`define CMAS_OFF_PTR0_HI 7'h05
`define CMAS_OFF_PTR1_LO 7'h06
`define CMAS_OFF_PTR1_HI 7'h07
`define CMAS_OFF_BSR 7'h08
`define CMAS_OFF_WORKING_ACCUMULATOR 7'h09
`define CMAS_OFF_PROGRAM_COUNTER_LATCH_HIGH 7'h0a
`define CMAS_OFF_INTERRUPT_CONTROL 7'h0b
`define CMAS_CORE_END 7'h0c
`define CMAS_GPR_START 7'h20
`define CMAS_COMMON_START 7'h70

// Power control flags register, full data address (bank 1).
`define CMAS_POWER_CONTROL_FLAGS_ADDR 12'h096
`define CMAS_POWER_CONTROL_FLAGS_OVF_BIT 7
`define CMAS_POWER_CONTROL_FLAGS_UNF_BIT 6

// Pointer high byte bit that selects program memory.
`define CMAS_PTR_PM_BIT 15

// Status register fields.
`define CMAS_ST_TO_N_BIT 4
`define CMAS_ST_PD_BIT 3
`define CMAS_ST_Z_BIT 2
`define CMAS_ST_DC_BIT 1
`define CMAS_ST_C_BIT 0
`define CMAS_ST_TO_N_RST 1'b1
`define CMAS_ST_PD_RST 1'b1
`define CMAS_ST_FLAG_RST 1'b0

`endif

// ---- cmas_core.v ----
// Core memory addressing, return stack, program counter and status flags.
//
// Operation
// RULE1 - Return stack holds sixteen 15-bit addresses.
// RULE2 - Stack overflow/underflow sets its flag; optional software reset follows.
// RULE3 - Two 16-bit pointers reach all file registers and program memory.
// RULE4 - Pointer reads of program memory take one extra cycle.
// RULE5 - Pointer high bit 7 set makes its data port read program memory.
// RULE6 - Indirect move to working register loads low 8 bits of word.
// RULE7 - Writes through a data port never change program memory.
// RULE8 - Program counter is 15 bits wide, 32K word space.
// RULE9 - Only 4096 words exist; addresses wrap at 0fffh.
// RULE10 - Reset starts at 0000h; interrupt vectors to 0004h.
// RULE11 - Data memory is 32 banks of 128 bytes, partitioned.
// RULE12 - Direct accesses use the bank last written to bank select.
// RULE13 - Unimplemented data locations read zero.
// RULE14 - Twelve core registers sit at the first addresses of each bank.
// RULE15 - Flag-updating instructions override status writes to zero, nibble carry, carry.
// RULE16 - Software cannot write watchdog-expiry or power-down bits.
// RULE17 - Status bits 7..5 read zero; bits 4..0 hold the flags.
// RULE18 - Watchdog-expiry bit set on power-up, clear or sleep; cleared on timeout.
// RULE19 - Power-down bit set on power-up or watchdog clear; cleared by sleep.
// RULE20 - Zero flag follows whether the result equals zero.
// RULE21 - Nibble carry flag is carry out of bit 3.
// RULE22 - Carry flag is carry out of bit 7; borrow inverted.
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "cmas_defines.vh"

module cmas_core (
   // Clock and reset
   input wire sys_clk,
   input wire nrst,
   // Register port
   input wire [6:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire ind_to_w,
   output wire [7:0] reg_rdata,
   output wire reg_rvalid,
   output wire extra_cycle,
   // Program memory read port used by pointer reads
   output wire [11:0] pm_addr,
   output wire pm_req,
   input wire [13:0] pm_rdata,
   // Program sequencing
   input wire pc_step,
   input wire pc_jump,
   input wire call_take,
   input wire ret_take,
   input wire int_take,
   input wire [14:0] jump_target,
   output wire [14:0] prog_counter,
   output wire [11:0] fetch_addr,
   output wire [4:0] stack_depth,
   // Stack fault reset
   input wire stack_reset_en,
   output wire soft_reset,
   // Arithmetic results
   input wire alu_en,
   input wire [7:0] alu_a,
   input wire [7:0] alu_b,
   input wire alu_sub,
   input wire alu_upd_z,
   input wire alu_upd_dcc,
   // Power and watchdog events
   input wire wdt_clear,
   input wire sleep_exec,
   input wire wdt_timeout,
   // Visible state
   output wire [7:0] status_out,
   output wire [7:0] working_accumulator_out,
   output wire [4:0] bank_out
);

   // Architectural registers and the next values of the flags.
   reg [14:0] pc_r;
   reg [15:0] ptr0_r, ptr1_r;
   reg [4:0] bsr_r;
   reg [7:0] working_accumulator_r, interrupt_control_r;
   reg [6:0] program_counter_latch_high_r;
   reg to_n_r, pd_r, z_r, dc_r, c_r, ovf_r, unf_r;
   reg to_n_nxt, pd_nxt, z_nxt, dc_nxt, c_nxt, ovf_nxt, unf_nxt;

   // Return stack and data memory; reset leaves their contents alone.
   reg [14:0] stack_mem [0:15];
   reg [4:0] sp_r;
   reg [7:0] gpr_mem [0:2559];
   reg [7:0] common_mem [0:15];

   // Bus answer and pointer read pipeline.
   reg [7:0] rdata_r;
   reg [11:0] pm_addr_r;
   reg rvalid_r, pm_req_r, pm_to_w_r, soft_reset_r;

   // Address decode.
   reg [15:0] ptr;
   reg [11:0] eff, gidx;
   reg [6:0] off;
   reg [7:0] rd_val;
   reg ind_sel, ptr_pm, eff_ok;

   // Arithmetic flag computation.
   wire [7:0] alu_bb, status_byte;
   wire [8:0] sum9;
   wire [4:0] sum5;

   // Sequencing decisions.
   reg [14:0] push_val, pc_nxt;
   reg push_req, pop_req, fault;
   wire stack_full, stack_empty, wr_core, wr_status, wr_pcl, wr_power_control_flags;

   assign reg_rdata = rdata_r;
   assign reg_rvalid = rvalid_r;
   assign extra_cycle = pm_req_r;
   assign pm_addr = pm_addr_r;
   assign pm_req = pm_req_r;
   assign prog_counter = pc_r;
   assign fetch_addr = pc_r[11:0]; // RULE9
   assign stack_depth = sp_r;
   assign soft_reset = soft_reset_r;
   assign status_out = status_byte;
   assign working_accumulator_out = working_accumulator_r;
   assign bank_out = bsr_r;

   assign status_byte = {3'h0, to_n_r, pd_r, z_r, dc_r, c_r}; // RULE17

   // Subtraction adds the two's complement of the second operand.
   assign alu_bb = alu_sub ? ~alu_b : alu_b; // RULE22
   assign sum9 = {1'b0, alu_a} + {1'b0, alu_bb} + {8'h00, alu_sub};
   assign sum5 = {1'b0, alu_a[3:0]} + {1'b0, alu_bb[3:0]} + {4'h0, alu_sub}; // RULE21

   // Effective address: direct from the bank, or through a pointer.
   always @*
   begin
      ind_sel = (reg_addr == `CMAS_OFF_IND0) || (reg_addr == `CMAS_OFF_IND1);
      ptr = reg_addr[0] ? ptr1_r : ptr0_r; // RULE3
      ptr_pm = ind_sel & ptr[`CMAS_PTR_PM_BIT]; // RULE5
      eff = {bsr_r, reg_addr}; // RULE12
      eff_ok = 1'b1;
      if (ind_sel)
      begin
         eff = ptr[11:0];
         eff_ok = ~ptr[15] & (ptr[14:12] == 3'h0) & (ptr[6:1] != 6'h00);
      end
      off = eff[6:0];
      gidx = ({7'h00, eff[11:7]} << 6) + ({7'h00, eff[11:7]} << 4)
             + {5'h00, off - `CMAS_GPR_START}; // RULE11
   end

   // Read value of the effective data address.
   always @*
   begin
      rd_val = 8'h00; // RULE13
      if (eff_ok)
      begin
         if (off < `CMAS_CORE_END)
         begin
            case (off) // RULE14
               `CMAS_OFF_PCL: rd_val = pc_r[7:0];
               `CMAS_OFF_STATUS: rd_val = status_byte;
               `CMAS_OFF_PTR0_LO: rd_val = ptr0_r[7:0];
               `CMAS_OFF_PTR0_HI: rd_val = ptr0_r[15:8];
               `CMAS_OFF_PTR1_LO: rd_val = ptr1_r[7:0];
               `CMAS_OFF_PTR1_HI: rd_val = ptr1_r[15:8];
               `CMAS_OFF_BSR: rd_val = {3'h0, bsr_r};
               `CMAS_OFF_WORKING_ACCUMULATOR: rd_val = working_accumulator_r;
               `CMAS_OFF_PROGRAM_COUNTER_LATCH_HIGH: rd_val = {1'b0, program_counter_latch_high_r};
               `CMAS_OFF_INTERRUPT_CONTROL: rd_val = interrupt_control_r;
               default: rd_val = 8'h00;
            endcase
         end
         else if (off >= `CMAS_COMMON_START)
            rd_val = common_mem[off[3:0]];
         else if (off >= `CMAS_GPR_START)
            rd_val = gpr_mem[gidx];
         else if (eff == `CMAS_POWER_CONTROL_FLAGS_ADDR)
            rd_val = {ovf_r, unf_r, 6'h00};
      end
   end

   assign wr_core = reg_wr & eff_ok & (off < `CMAS_CORE_END);
   assign wr_status = wr_core & (off == `CMAS_OFF_STATUS);
   assign wr_pcl = wr_core & (off == `CMAS_OFF_PCL);
   assign wr_power_control_flags = reg_wr & eff_ok & (eff == `CMAS_POWER_CONTROL_FLAGS_ADDR);

   assign stack_full = (sp_r == 5'h10); // RULE1
   assign stack_empty = (sp_r == 5'h00);

   // Program counter sequencing and stack requests.
   always @*
   begin
      push_req = 1'b0;
      pop_req = 1'b0;
      push_val = pc_r;
      pc_nxt = pc_r;
      if (int_take)
      begin
         push_req = 1'b1;
         pc_nxt = `CMAS_INT_VECTOR; // RULE10
      end
      else if (ret_take)
      begin
         pop_req = 1'b1;
         pc_nxt = stack_empty ? `CMAS_RESET_VECTOR : stack_mem[sp_r[3:0] - 4'h1];
      end
      else if (call_take)
      begin
         push_req = 1'b1;
         push_val = pc_r + 15'h0001;
         pc_nxt = jump_target;
      end
      else if (wr_pcl)
         pc_nxt = {program_counter_latch_high_r, reg_wdata};
      else if (pc_jump)
         pc_nxt = jump_target;
      else if (pc_step)
         pc_nxt = pc_r + 15'h0001; // RULE8
      fault = (push_req & stack_full) | (pop_req & stack_empty);
   end

   // Status and power control flags; hardware events win over writes.
   always @*
   begin
      to_n_nxt = to_n_r; // RULE16
      pd_nxt = pd_r;
      if (wdt_timeout)
         to_n_nxt = 1'b0; // RULE18
      else if (wdt_clear)
      begin
         to_n_nxt = 1'b1;
         pd_nxt = 1'b1; // RULE19
      end
      else if (sleep_exec)
      begin
         to_n_nxt = 1'b1;
         pd_nxt = 1'b0;
      end
      z_nxt = wr_status ? reg_wdata[`CMAS_ST_Z_BIT] : z_r;
      dc_nxt = wr_status ? reg_wdata[`CMAS_ST_DC_BIT] : dc_r;
      c_nxt = wr_status ? reg_wdata[`CMAS_ST_C_BIT] : c_r;
      if (alu_en & alu_upd_z)
         z_nxt = (sum9[7:0] == 8'h00); // RULE15 RULE20
      if (alu_en & alu_upd_dcc)
      begin
         dc_nxt = sum5[4]; // RULE15 RULE21
         c_nxt = sum9[8]; // RULE22
      end
      ovf_nxt = (push_req & stack_full) | (wr_power_control_flags ? ovf_r & reg_wdata[7] : ovf_r); // RULE2
      unf_nxt = (pop_req & stack_empty) | (wr_power_control_flags ? unf_r & reg_wdata[6] : unf_r); // RULE2
   end

   // Control state.
   always @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pc_r <= `CMAS_RESET_VECTOR; // RULE10
         sp_r <= 5'h00;
         ptr0_r <= 16'h0000;
         ptr1_r <= 16'h0000;
         bsr_r <= 5'h00;
         working_accumulator_r <= 8'h00;
         program_counter_latch_high_r <= 7'h00;
         interrupt_control_r <= 8'h00;
         to_n_r <= `CMAS_ST_TO_N_RST;
         pd_r <= `CMAS_ST_PD_RST;
         z_r <= `CMAS_ST_FLAG_RST;
         dc_r <= `CMAS_ST_FLAG_RST;
         c_r <= `CMAS_ST_FLAG_RST;
         ovf_r <= 1'b0;
         unf_r <= 1'b0;
         rdata_r <= 8'h00;
         rvalid_r <= 1'b0;
         pm_req_r <= 1'b0;
         pm_addr_r <= 12'h000;
         pm_to_w_r <= 1'b0;
         soft_reset_r <= 1'b0;
      end
      else
      begin
         to_n_r <= to_n_nxt;
         pd_r <= pd_nxt;
         z_r <= z_nxt;
         dc_r <= dc_nxt;
         c_r <= c_nxt;
         ovf_r <= ovf_nxt;
         unf_r <= unf_nxt;
         soft_reset_r <= fault & stack_reset_en; // RULE2

         // Sequencing, with the stack fault reset taking precedence.
         if (fault & stack_reset_en)
         begin
            pc_r <= `CMAS_RESET_VECTOR;
            sp_r <= 5'h00;
         end
         else
         begin
            pc_r <= pc_nxt;
            if (push_req & ~stack_full)
               sp_r <= sp_r + 5'h01;
            else if (pop_req & ~stack_empty)
               sp_r <= sp_r - 5'h01;
         end

         // Core register writes.
         if (wr_core)
         begin
            case (off)
               `CMAS_OFF_PTR0_LO: ptr0_r[7:0] <= reg_wdata;
               `CMAS_OFF_PTR0_HI: ptr0_r[15:8] <= reg_wdata;
               `CMAS_OFF_PTR1_LO: ptr1_r[7:0] <= reg_wdata;
               `CMAS_OFF_PTR1_HI: ptr1_r[15:8] <= reg_wdata;
               `CMAS_OFF_BSR: bsr_r <= reg_wdata[4:0];
               `CMAS_OFF_PROGRAM_COUNTER_LATCH_HIGH: program_counter_latch_high_r <= reg_wdata[6:0];
               `CMAS_OFF_INTERRUPT_CONTROL: interrupt_control_r <= reg_wdata;
               default: ;
            endcase
         end

         // Reads: data memory answers next cycle, program memory one later.
         pm_req_r <= reg_rd & ptr_pm; // RULE4
         rvalid_r <= (reg_rd & ~ptr_pm) | pm_req_r;
         if (reg_rd & ptr_pm)
         begin
            pm_addr_r <= ptr[11:0]; // RULE9
            pm_to_w_r <= ind_to_w;
         end
         if (reg_rd & ~ptr_pm)
         begin
            rdata_r <= rd_val;
            if (ind_to_w)
               working_accumulator_r <= rd_val;
         end
         else if (pm_req_r)
         begin
            rdata_r <= pm_rdata[7:0]; // RULE6
            if (pm_to_w_r)
               working_accumulator_r <= pm_rdata[7:0]; // RULE6
         end
         else if (wr_core & (off == `CMAS_OFF_WORKING_ACCUMULATOR))
            working_accumulator_r <= reg_wdata;
      end
   end

   // Return stack storage; a push onto a full stack is dropped.
   always @(posedge sys_clk)
   begin
      if (push_req & ~stack_full & ~(fault & stack_reset_en))
         stack_mem[sp_r[3:0]] <= push_val; // RULE1
   end

   // General purpose and common RAM; program memory is never written.
   always @(posedge sys_clk)
   begin
      if (reg_wr & eff_ok & ~ptr_pm) // RULE7
      begin
         if (off >= `CMAS_COMMON_START)
            common_mem[off[3:0]] <= reg_wdata;
         else if (off >= `CMAS_GPR_START)
            gpr_mem[gidx] <= reg_wdata; // RULE11
      end
   end

endmodule // cmas_core
`default_nettype wire

// ---- cmas_core_monitor.sv ----
// Concurrent checks on the ports of the core addressing and status block.
`timescale 1ns/1ps
`default_nettype none
module cmas_core_monitor (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // Register port
   input wire logic reg_rd,
   input wire logic reg_rvalid,
   input wire logic [7:0] reg_rdata,
   input wire logic extra_cycle,
   input wire logic pm_req,
   input wire logic [13:0] pm_rdata,
   // Sequencing
   input wire logic int_take,
   input wire logic [14:0] prog_counter,
   input wire logic [11:0] fetch_addr,
   input wire logic [4:0] stack_depth,
   input wire logic soft_reset,
   // Flags
   input wire logic alu_en,
   input wire logic [7:0] alu_a,
   input wire logic [7:0] alu_b,
   input wire logic alu_sub,
   input wire logic alu_upd_z,
   input wire logic alu_upd_dcc,
   input wire logic wdt_clear,
   input wire logic sleep_exec,
   input wire logic wdt_timeout,
   input wire logic [7:0] status_out
);
   wire [7:0] b_eff = alu_sub ? ~alu_b : alu_b;
   wire [8:0] alu_sum = {1'b0, alu_a} + {1'b0, b_eff} + {8'h00, alu_sub};
   wire [4:0] nib_sum = {1'b0, alu_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, alu_sub};
   reg [2:0] flg_r;
   reg [7:0] pm_lo_r;
   always @(posedge sys_clk)
   begin
      flg_r <= {alu_sum[7:0] == 8'h00, nib_sum[4], alu_sum[8]};
      pm_lo_r <= pm_rdata[7:0];
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   property p_pm_ans; pm_req |-> extra_cycle ##1 reg_rvalid && reg_rdata == pm_lo_r; endproperty
   a_pm_ans: assert property (p_pm_ans) else $error("program word answer wrong");
   property p_rd_ans; reg_rd |=> reg_rvalid || pm_req; endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
   property p_wrap; fetch_addr == prog_counter[11:0]; endproperty
   a_wrap: assert property (p_wrap) else $error("fetch address not wrapped");
   property p_int_vec; int_take |=> prog_counter == 15'h0004; endproperty
   a_int_vec: assert property (p_int_vec) else $error("interrupt vector wrong");
   property p_st_top; status_out[7:5] == 3'h0; endproperty
   a_st_top: assert property (p_st_top) else $error("status top bits set");
   property p_tmo; wdt_timeout |=> !status_out[4]; endproperty
   a_tmo: assert property (p_tmo) else $error("timeout flag not cleared");
   property p_sleep; sleep_exec && !wdt_timeout && !wdt_clear |=> status_out[4:3] == 2'h2; endproperty
   a_sleep: assert property (p_sleep) else $error("sleep flags wrong");
   property p_clr; wdt_clear && !wdt_timeout |=> status_out[4:3] == 2'h3; endproperty
   a_clr: assert property (p_clr) else $error("watchdog clear flags wrong");
   property p_zero; alu_en && alu_upd_z |=> status_out[2] == flg_r[2]; endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong");
   property p_carry; alu_en && alu_upd_dcc |=> status_out[1:0] == flg_r[1:0]; endproperty
   a_carry: assert property (p_carry) else $error("carry flags wrong");
   property p_depth; stack_depth <= 5'h10; endproperty
   a_depth: assert property (p_depth) else $error("stack deeper than sixteen");
   c_pm: cover property (pm_req);
   c_int: cover property (int_take);
   c_srst: cover property (soft_reset);
   c_tmo: cover property (wdt_timeout);
endmodule // cmas_core_monitor
bind cmas_core cmas_core_monitor i_cmas_core_monitor (
   .sys_clk(sys_clk), .nrst(nrst), .reg_rd(reg_rd), .reg_rvalid(reg_rvalid),
   .reg_rdata(reg_rdata), .extra_cycle(extra_cycle), .pm_req(pm_req), .pm_rdata(pm_rdata),
   .int_take(int_take), .prog_counter(prog_counter), .fetch_addr(fetch_addr),
   .stack_depth(stack_depth), .soft_reset(soft_reset), .alu_en(alu_en), .alu_a(alu_a),
   .alu_b(alu_b), .alu_sub(alu_sub), .alu_upd_z(alu_upd_z), .alu_upd_dcc(alu_upd_dcc),
   .wdt_clear(wdt_clear), .sleep_exec(sleep_exec), .wdt_timeout(wdt_timeout),
   .status_out(status_out));
`default_nettype wire

// ---- cmas_core_tb.sv ----
// Self-checking bench of the core addressing and status block.
`timescale 1ns/1ps
`default_nettype none
module cmas_core_tb;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic [11:0] ev = 12'h000;
   logic [6:0] reg_addr = 7'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic [14:0] jump_target = 15'h0000;
   logic stack_reset_en = 1'b0;
   logic [7:0] alu_a = 8'h00;
   logic [7:0] alu_b = 8'h00;
   logic alu_sub = 1'b0;
   logic alu_upd_z = 1'b0;
   logic alu_upd_dcc = 1'b0;
   wire [7:0] reg_rdata, status_out, working_accumulator_out;
   wire reg_rvalid, extra_cycle, pm_req, soft_reset;
   wire [11:0] pm_addr, fetch_addr;
   wire [13:0] pm_rdata;
   wire [14:0] prog_counter;
   wire [4:0] stack_depth, bank_out;
   int num_errors = 0;
   int compares = 0;
   int cyc = 0;
   // Each program word carries its own address, so low byte and wrap both show.
   assign pm_rdata = {pm_addr[1:0], pm_addr};
   always #2.5 sys_clk = ~sys_clk;
   cmas_core i_cmas_core (
      .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(ev[0]), .reg_rd(ev[1]), .ind_to_w(ev[11]), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .extra_cycle(extra_cycle), .pm_addr(pm_addr),
      .pm_req(pm_req), .pm_rdata(pm_rdata), .pc_step(ev[2]), .pc_jump(ev[3]),
      .call_take(ev[4]), .ret_take(ev[5]), .int_take(ev[6]), .jump_target(jump_target),
      .prog_counter(prog_counter), .fetch_addr(fetch_addr), .stack_depth(stack_depth),
      .stack_reset_en(stack_reset_en), .soft_reset(soft_reset), .alu_en(ev[10]),
      .alu_a(alu_a), .alu_b(alu_b), .alu_sub(alu_sub), .alu_upd_z(alu_upd_z),
      .alu_upd_dcc(alu_upd_dcc), .wdt_clear(ev[7]), .sleep_exec(ev[8]),
      .wdt_timeout(ev[9]), .status_out(status_out), .working_accumulator_out(working_accumulator_out), .bank_out(bank_out));
   task automatic conclude();
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic op(input logic [11:0] e, input logic [6:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      ev <= e;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      ev <= 12'h000;
      #1;
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] exp);
      op(12'h002, a, 8'h00);
      chk(16'({reg_rvalid, reg_rdata}), 16'({1'b1, exp}));
   endtask
   task automatic alu(input logic [2:0] m, input logic [15:0] ab, input logic [11:0] e,
                      input logic [7:0] d, input logic [7:0] exp);
      @(posedge sys_clk);
      {alu_upd_z, alu_upd_dcc, alu_sub} <= m;
      {alu_a, alu_b} <= ab;
      op(e, 7'h03, d);
      chk(16'(status_out), 16'(exp));
   endtask
   task automatic pc(input logic [11:0] e, input logic [14:0] t, input logic [14:0] exp);
      @(posedge sys_clk);
      jump_target <= t;
      op(e, 7'h00, 8'h00);
      chk(16'(prog_counter), 16'(exp));
   endtask
   task automatic t_bank();
      op(12'h001, 7'h08, 8'h03);
      op(12'h001, 7'h20, 8'ha5);
      op(12'h001, 7'h70, 8'h77);
      op(12'h001, 7'h08, 8'h04);
      op(12'h001, 7'h20, 8'h5a);
      chk(16'(bank_out), 16'h0004);
      rd(7'h70, 8'h77);
      op(12'h001, 7'h08, 8'h03);
      rd(7'h20, 8'ha5);
      rd(7'h0c, 8'h00);
      op(12'h001, 7'h09, 8'h3c);
      rd(7'h09, 8'h3c);
      chk(16'(working_accumulator_out), 16'h003c);
      op(12'h802, 7'h70, 8'h00);
      chk(16'(working_accumulator_out), 16'h0077);
   endtask
   task automatic t_ptr();
      // A data byte at the address a leaked program memory write would hit.
      op(12'h001, 7'h06, 8'h23);
      op(12'h001, 7'h07, 8'h01);
      op(12'h001, 7'h01, 8'h5c);
      op(12'h001, 7'h04, 8'h23);
      op(12'h001, 7'h05, 8'hf1);
      op(12'h802, 7'h00, 8'h00);
      chk(16'({extra_cycle, pm_req, reg_rvalid}), 16'h0006);
      chk(16'(pm_addr), 16'h0123);
      @(posedge sys_clk);
      #1;
      chk(16'({reg_rvalid, reg_rdata}), 16'h0123);
      chk(16'(working_accumulator_out), 16'h0023);
      op(12'h001, 7'h00, 8'hee);
      op(12'h002, 7'h00, 8'h00);
      @(posedge sys_clk);
      #1;
      chk(16'(reg_rdata), 16'h0023);
      rd(7'h01, 8'h5c);
      op(12'h001, 7'h06, 8'ha0);
      op(12'h001, 7'h07, 8'h01);
      rd(7'h01, 8'ha5);
      op(12'h001, 7'h01, 8'h66);
      rd(7'h20, 8'h66);
   endtask
   task automatic t_status();
      op(12'h001, 7'h03, 8'hff);
      chk(16'(status_out), 16'h001f);
      op(12'h001, 7'h03, 8'h00);
      chk(16'(status_out), 16'h0018);
      alu(3'h6, 16'h0f01, 12'h400, 8'h00, 8'h1a);
      alu(3'h6, 16'h8080, 12'h401, 8'h00, 8'h1d);
      alu(3'h7, 16'h0505, 12'h400, 8'h00, 8'h1f);
      alu(3'h7, 16'h0305, 12'h400, 8'h00, 8'h18);
      alu(3'h2, 16'h0000, 12'h401, 8'hff, 8'h1c);
      op(12'h200, 7'h00, 8'h00);
      chk(16'(status_out[4:3]), 16'h0001);
      op(12'h100, 7'h00, 8'h00);
      chk(16'(status_out[4:3]), 16'h0002);
      op(12'h080, 7'h00, 8'h00);
      chk(16'(status_out[4:3]), 16'h0003);
   endtask
   task automatic t_pc();
      pc(12'h008, 15'h7fff, 15'h7fff);
      chk(16'(fetch_addr), 16'h0fff);
      pc(12'h008, 15'h0020, 15'h0020);
      pc(12'h004, 15'h0000, 15'h0021);
      pc(12'h010, 15'h0100, 15'h0100);
      pc(12'h040, 15'h0000, 15'h0004);
      pc(12'h020, 15'h0000, 15'h0100);
      pc(12'h020, 15'h0000, 15'h0022);
      pc(12'h020, 15'h0000, 15'h0000);
      op(12'h001, 7'h08, 8'h01);
      rd(7'h16, 8'h40);
      op(12'h001, 7'h16, 8'h00);
      repeat (17) pc(12'h010, 15'h0200, 15'h0200);
      chk(16'(stack_depth), 16'h0010);
      rd(7'h16, 8'h80);
      @(posedge sys_clk);
      stack_reset_en <= 1'b1;
      op(12'h010, 7'h00, 8'h00);
      for (int i = 0; i < 3 && soft_reset !== 1'b1; i++)
      begin
         @(posedge sys_clk);
         #1;
      end
      chk(16'(soft_reset), 16'h0001);
      @(posedge sys_clk);
      #1;
      chk(16'({stack_depth, prog_counter}), 16'h0000);
      op(12'h001, 7'h0a, 8'h12);
      op(12'h001, 7'h02, 8'h34);
      chk(16'(prog_counter), 16'h1234);
   endtask
   task automatic t_reset();
      @(posedge sys_clk);
      nrst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      #1;
      chk(16'(status_out), 16'h0018);
      chk(16'(bank_out), 16'h0000);
      chk(16'(prog_counter), 16'h0000);
   endtask
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         num_errors++;
         conclude();
      end
   end
   initial
   begin
      repeat (4) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      #1;
      chk(16'(status_out), 16'h0018);
      chk(16'(prog_counter), 16'h0000);
      t_bank();
      t_ptr();
      t_status();
      t_pc();
      t_reset();
      conclude();
   end
endmodule // cmas_core_tb
`default_nettype wire
